//--- logic/tbg_consts.svh
// register offsets, field positions, reset values and timing counts of the timer
`ifndef TBG_CONSTS_SVH
`define TBG_CONSTS_SVH

`define TBG_ADDR_W 12
`define TBG_OFF_CONTROL 12'h000
`define TBG_OFF_MODE 12'h004
`define TBG_OFF_RELOAD_LO 12'h008
`define TBG_OFF_RELOAD_HI 12'h00C
`define TBG_OFF_COUNT_LO 12'h010
`define TBG_OFF_COUNT_HI 12'h014

`define TBG_CTL_OVF 7
`define TBG_CTL_EXT 6
`define TBG_CTL_RXSEL 5
`define TBG_CTL_TXSEL 4
`define TBG_CTL_EXEN 3
`define TBG_CTL_RUN 2
`define TBG_CTL_CTSEL 1
`define TBG_CTL_CPRL 0
`define TBG_MODE_OE 1
`define TBG_MODE_DOWN_COUNT_ENABLE 0

`define TBG_CTL_RST 8'h00
`define TBG_MODE_RST 2'h0
`define TBG_RELOAD_RST 16'h0000
`define TBG_COUNT_RST 16'h0000
`define TBG_COUNT_TOP 16'hFFFF

`define TBG_OSC_PERIOD_NS 100
`define TBG_MACHINE_OSC 12
`define TBG_STATE_OSC 2
`define TBG_BAUD_DIV 16

`endif

//--- logic/tbg_pkg.sv
// types shared by the timer modules
`default_nettype none
package tbg_pkg;
  typedef enum logic [1:0] {tbg_auto_up, tbg_up_down, tbg_baud} tbg_mode_t;
  typedef enum logic [2:0] {tbg_reg_control, tbg_reg_mode, tbg_reg_rlo, tbg_reg_rhi,
                            tbg_reg_clo, tbg_reg_chi, tbg_reg_none} tbg_reg_t;
endpackage : tbg_pkg
`default_nettype wire

//--- logic/tbg_evt_if.sv
// ticks and pin events passed from the helpers to the timer core
`timescale 1ns/1ps
`default_nettype none
interface tbg_evt_if;
  logic machine_tick;
  logic state_tick;
  logic trig_fall;
  logic trig_level;
  logic cnt_fall;
  modport tick_src (output machine_tick, output state_tick);
  modport pin_src (output trig_fall, output trig_level, output cnt_fall);
  modport core (input machine_tick, input state_tick, input trig_fall, input trig_level, input cnt_fall);
endinterface : tbg_evt_if
`default_nettype wire

//--- logic/tbg_tick_gen.sv
// machine cycle and state time tick generator
`timescale 1ns/1ps
`default_nettype none
`include "tbg_consts.svh"
module tbg_tick_gen #(
  parameter int MACHINE_CYC = `TBG_MACHINE_OSC,
  parameter int STATE_CYC = `TBG_STATE_OSC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  tbg_evt_if.tick_src evt
);
  logic [3:0] mach_cnt;
  logic [1:0] state_cnt;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mach_cnt <= 4'h0;
    end else if (mach_cnt == 4'(MACHINE_CYC - 1)) begin
      mach_cnt <= 4'h0;
    end else begin
      mach_cnt <= mach_cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_cnt <= 2'h0;
    end else if (state_cnt == 2'(STATE_CYC - 1)) begin
      state_cnt <= 2'h0;
    end else begin
      state_cnt <= state_cnt + 2'h1;
    end
  end

  // one pulse per machine cycle and per state time
  assign evt.machine_tick = (mach_cnt == 4'(MACHINE_CYC - 1));
  assign evt.state_tick = (state_cnt == 2'(STATE_CYC - 1));

  machine_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    evt.machine_tick |=> !evt.machine_tick [*8]) else $error("machine tick too frequent");
endmodule : tbg_tick_gen
`default_nettype wire

//--- logic/tbg_pin_sync.sv
// synchroniser and falling edge detect for trigger and count pins
`timescale 1ns/1ps
`default_nettype none
module tbg_pin_sync (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic trig_pin,
  input wire logic cnt_pin,
  tbg_evt_if.pin_src evt
);
  logic [1:0] pin_raw;
  logic [1:0] meta;
  logic [1:0] stab;
  logic [1:0] prev;

  assign pin_raw = {cnt_pin, trig_pin};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          meta[g] <= 1'b1;
          stab[g] <= 1'b1;
          prev[g] <= 1'b1;
        end else begin
          meta[g] <= pin_raw[g];
          stab[g] <= meta[g];
          prev[g] <= stab[g];
        end
      end
    end
  endgenerate

  assign evt.trig_level = stab[0];
  assign evt.trig_fall = prev[0] & ~stab[0];
  assign evt.cnt_fall = prev[1] & ~stab[1];
endmodule : tbg_pin_sync
`default_nettype wire

//--- logic/tbg_timer.sv
// reload timer with up/down counting and baud generation behind an apb slave
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tbg_consts.svh"

// Overview of operation
// - down-count enable resets 0; direction pin steers
// - up-count to FFFF, flag overflow, reload
// - external falling edge reloads and sets edge flag
// - interrupt request from overflow or edge flag
// - direction high counts up, overflow reloads
// - direction low counts down, underflow loads FFFF
// - edge flag toggles on wrap, no interrupt
// - select bits pick this timer per direction
// - baud rollover reloads both count bytes
// - baud clock is overflow rate over 16
// - timer ticks per machine cycle, baud per state
// - internal baud rate osc over 32 times span
// - baud mode may count external input edges
// - baud rollover sets no overflow flag
// - baud mode edge sets flag without reload
// - control encodings 00 08 34 36 24 26 14 16
// - reserved mode bits written 0, read undefined
// - counter select counts external falling edges
// - baud selects force auto-reload, ignore capture select
module tbg_timer (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TBG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_direction_input,
  input wire logic external_count_input,
  input wire logic timer1_overflow,
  output logic timer_irq_req,
  output logic tx_baud_clk,
  output logic rx_baud_clk,
  output logic timer_output_enable
);
  tbg_evt_if evt ();

  tbg_tick_gen u_tick (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .evt(evt.tick_src)
  );

  tbg_pin_sync u_pins (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .trig_pin(trigger_direction_input),
    .cnt_pin(external_count_input),
    .evt(evt.pin_src)
  );

  function automatic tbg_pkg::tbg_reg_t tbg_reg_index(input logic [`TBG_ADDR_W-1:0] addr);
    case (addr)
      `TBG_OFF_CONTROL: tbg_reg_index = tbg_pkg::tbg_reg_control;
      `TBG_OFF_MODE: tbg_reg_index = tbg_pkg::tbg_reg_mode;
      `TBG_OFF_RELOAD_LO: tbg_reg_index = tbg_pkg::tbg_reg_rlo;
      `TBG_OFF_RELOAD_HI: tbg_reg_index = tbg_pkg::tbg_reg_rhi;
      `TBG_OFF_COUNT_LO: tbg_reg_index = tbg_pkg::tbg_reg_clo;
      `TBG_OFF_COUNT_HI: tbg_reg_index = tbg_pkg::tbg_reg_chi;
      default: tbg_reg_index = tbg_pkg::tbg_reg_none;
    endcase
  endfunction : tbg_reg_index

  // control and mode register fields, reload and count registers
  logic ovf_flag;
  logic ext_flag;
  logic rx_sel;
  logic tx_sel;
  logic ext_en;
  logic run;
  logic ct_sel;
  logic cap_rl_sel;
  logic oe_bit;
  logic down_count_enable;
  logic [15:0] reload;
  logic [15:0] count;

  logic wr;
  tbg_pkg::tbg_reg_t acc_idx;
  tbg_pkg::tbg_reg_t setup_idx;
  logic wr_ctl;

  assign acc_idx = tbg_reg_index(paddr);
  assign setup_idx = tbg_reg_index(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & (acc_idx == tbg_pkg::tbg_reg_none);
  assign wr = psel & penable & pwrite;
  assign wr_ctl = wr & (acc_idx == tbg_pkg::tbg_reg_control);

  // counting mode and tick selection
  tbg_pkg::tbg_mode_t mode;
  logic baud_on;
  logic adv;

  assign baud_on = rx_sel | tx_sel;

  always_comb begin
    if (baud_on) begin
      mode = tbg_pkg::tbg_baud;
    end else if (down_count_enable) begin
      mode = tbg_pkg::tbg_up_down;
    end else begin
      mode = tbg_pkg::tbg_auto_up;
    end
  end

  always_comb begin
    if (ct_sel) begin
      adv = run & evt.cnt_fall;
    end else if (baud_on) begin
      adv = run & evt.state_tick;
    end else begin
      adv = run & evt.machine_tick;
    end
  end

  // next count and flag events
  logic [15:0] next_count;
  logic hw_load;
  logic set_ovf;
  logic set_ext;
  logic flip_ext;
  logic baud_wrap;

  always_comb begin
    next_count = count;
    hw_load = 1'b0;
    set_ovf = 1'b0;
    set_ext = 1'b0;
    flip_ext = 1'b0;
    baud_wrap = 1'b0;
    case (mode)
      tbg_pkg::tbg_baud: begin
        if (adv) begin
          hw_load = 1'b1;
          if (count == `TBG_COUNT_TOP) begin
            next_count = reload;
            baud_wrap = 1'b1;
          end else begin
            next_count = count + 16'h0001;
          end
        end
        if (ext_en && evt.trig_fall) begin
          set_ext = 1'b1;
        end
      end
      tbg_pkg::tbg_up_down: begin
        if (adv) begin
          hw_load = 1'b1;
          if (evt.trig_level) begin
            if (count == `TBG_COUNT_TOP) begin
              next_count = reload;
              set_ovf = 1'b1;
              flip_ext = 1'b1;
            end else begin
              next_count = count + 16'h0001;
            end
          end else begin
            if (count == reload) begin
              next_count = `TBG_COUNT_TOP;
              set_ovf = 1'b1;
              flip_ext = 1'b1;
            end else begin
              next_count = count - 16'h0001;
            end
          end
        end
      end
      default: begin
        if (adv) begin
          hw_load = 1'b1;
          if (count == `TBG_COUNT_TOP) begin
            next_count = reload;
            set_ovf = 1'b1;
          end else begin
            next_count = count + 16'h0001;
          end
        end
        if (ext_en && evt.trig_fall) begin
          hw_load = 1'b1;
          next_count = reload;
          set_ext = 1'b1;
        end
      end
    endcase
  end

  // control register: hardware set wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      {ovf_flag, ext_flag, rx_sel, tx_sel, ext_en, run, ct_sel, cap_rl_sel} <= `TBG_CTL_RST;
    end else begin
      if (wr_ctl) begin
        rx_sel <= pwdata[`TBG_CTL_RXSEL];
        tx_sel <= pwdata[`TBG_CTL_TXSEL];
        ext_en <= pwdata[`TBG_CTL_EXEN];
        run <= pwdata[`TBG_CTL_RUN];
        ct_sel <= pwdata[`TBG_CTL_CTSEL];
        cap_rl_sel <= pwdata[`TBG_CTL_CPRL];
      end
      if (set_ovf) begin
        ovf_flag <= 1'b1;
      end else if (wr_ctl) begin
        ovf_flag <= pwdata[`TBG_CTL_OVF];
      end
      if (flip_ext) begin
        ext_flag <= ~ext_flag;
      end else if (set_ext) begin
        ext_flag <= 1'b1;
      end else if (wr_ctl) begin
        ext_flag <= pwdata[`TBG_CTL_EXT];
      end
    end
  end

  // mode register; reserved bits are not stored
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      {oe_bit, down_count_enable} <= `TBG_MODE_RST;
    end else if (wr && acc_idx == tbg_pkg::tbg_reg_mode) begin
      oe_bit <= pwdata[`TBG_MODE_OE];
      down_count_enable <= pwdata[`TBG_MODE_DOWN_COUNT_ENABLE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reload <= `TBG_RELOAD_RST;
    end else if (wr && acc_idx == tbg_pkg::tbg_reg_rlo) begin
      reload[7:0] <= pwdata[7:0];
    end else if (wr && acc_idx == tbg_pkg::tbg_reg_rhi) begin
      reload[15:8] <= pwdata[7:0];
    end
  end

  // count: a hardware update in the same cycle beats a software write
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count <= `TBG_COUNT_RST;
    end else if (hw_load) begin
      count <= next_count;
    end else if (wr && acc_idx == tbg_pkg::tbg_reg_clo) begin
      count[7:0] <= pwdata[7:0];
    end else if (wr && acc_idx == tbg_pkg::tbg_reg_chi) begin
      count[15:8] <= pwdata[7:0];
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (setup_idx)
        tbg_pkg::tbg_reg_control: prdata <= {24'h00_0000, ovf_flag, ext_flag, rx_sel, tx_sel,
                                             ext_en, run, ct_sel, cap_rl_sel};
        tbg_pkg::tbg_reg_mode: prdata <= {30'h0000_0000, oe_bit, down_count_enable};
        tbg_pkg::tbg_reg_rlo: prdata <= {24'h00_0000, reload[7:0]};
        tbg_pkg::tbg_reg_rhi: prdata <= {24'h00_0000, reload[15:8]};
        tbg_pkg::tbg_reg_clo: prdata <= {24'h00_0000, count[7:0]};
        tbg_pkg::tbg_reg_chi: prdata <= {24'h00_0000, count[15:8]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // baud dividers: index 0 transmit, 1 receive
  logic [1:0] baud_sel;
  logic [1:0] baud_src;
  logic [1:0] baud_out;
  logic [3:0] baud_div [2];

  assign baud_sel = {rx_sel, tx_sel};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_baud
      assign baud_src[g] = baud_sel[g] ? baud_wrap : timer1_overflow;
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          baud_div[g] <= 4'h0;
          baud_out[g] <= 1'b0;
        end else begin
          baud_out[g] <= baud_src[g] && (baud_div[g] == 4'(`TBG_BAUD_DIV - 1));
          if (baud_src[g]) begin
            baud_div[g] <= baud_div[g] + 4'h1;
          end
        end
      end
    end
  endgenerate

  assign tx_baud_clk = baud_out[0];
  assign rx_baud_clk = baud_out[1];
  assign timer_output_enable = oe_bit;
  assign timer_irq_req = ovf_flag | (ext_flag & (mode != tbg_pkg::tbg_up_down));

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  down_count_enable_reset_a: assert property (!$past(rst_b) |-> !down_count_enable) else $error("down count enable not clear after reset");
  up_reload_a: assert property (mode == tbg_pkg::tbg_auto_up && adv && count == `TBG_COUNT_TOP && !(ext_en && evt.trig_fall)
    |=> count == $past(reload) && ovf_flag) else $error("auto reload overflow wrong");
  ext_reload_a: assert property (mode == tbg_pkg::tbg_auto_up && ext_en && evt.trig_fall
    |=> ext_flag && count == $past(reload)) else $error("external reload wrong");
  irq_flag_a: assert property (mode == tbg_pkg::tbg_auto_up && (ovf_flag || ext_flag)
    |-> timer_irq_req) else $error("flag gives no request");
  up_wrap_a: assert property (mode == tbg_pkg::tbg_up_down && adv && evt.trig_level && count == `TBG_COUNT_TOP
    |=> count == $past(reload) && ovf_flag) else $error("up count wrap wrong");
  down_under_a: assert property (mode == tbg_pkg::tbg_up_down && adv && !evt.trig_level && count == reload
    |=> count == `TBG_COUNT_TOP && ovf_flag) else $error("underflow wrong");
  ext_toggle_a: assert property (flip_ext |=> ext_flag != $past(ext_flag)) else $error("edge flag did not toggle");
  baud_noflag_a: assert property (baud_wrap && !wr_ctl && !ovf_flag
    |=> !ovf_flag && count == $past(reload)) else $error("baud rollover wrong");
  baud_noreload_a: assert property (mode == tbg_pkg::tbg_baud && ext_en && evt.trig_fall && !adv && !wr
    |=> ext_flag && count == $past(count)) else $error("baud edge reloaded count");
  tx_div_a: assert property (tx_sel && baud_wrap && baud_div[0] == 4'hF |=> tx_baud_clk) else $error("tx divide wrong");

  baud_wrap_c: cover property (baud_wrap);
  down_under_c: cover property (mode == tbg_pkg::tbg_up_down && set_ovf && !evt.trig_level);
  ext_reload_c: cover property (mode == tbg_pkg::tbg_auto_up && set_ext);
endmodule : tbg_timer
`default_nettype wire

//--- test/tbg_far_side.sv
// far side model: trigger and count pins, other timer overflow, baud pulse counters
`timescale 1ns/1ps
`default_nettype none
module tbg_far_side (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic tx_baud_clk,
  input wire logic rx_baud_clk,
  output logic trigger_direction_input,
  output logic external_count_input,
  output logic timer1_overflow
);
  int tx_n = 0;
  int rx_n = 0;
  logic [2:0] t1_div = 3'h0;
  initial begin
    trigger_direction_input = 1'b1;
    external_count_input = 1'b1;
    timer1_overflow = 1'b0;
  end
  // the other timer overflows once every 8 cycles
  always @(posedge sys_clk) begin
    t1_div <= rst_b ? t1_div + 3'h1 : 3'h0;
    timer1_overflow <= rst_b && (t1_div == 3'h7);
    if (tx_baud_clk === 1'b1) tx_n <= tx_n + 1;
    if (rx_baud_clk === 1'b1) rx_n <= rx_n + 1;
  end
  // each level held 4 cycles so the synchroniser sees it
  task set_trig(input logic v);
    trigger_direction_input <= v;
    repeat (4) @(posedge sys_clk);
  endtask : set_trig
  // the pin idles high, so the first toggle is the counted falling edge
  task pulse_cnt;
    external_count_input <= ~external_count_input;
    repeat (4) @(posedge sys_clk);
    external_count_input <= ~external_count_input;
    repeat (4) @(posedge sys_clk);
  endtask : pulse_cnt
endmodule : tbg_far_side
`default_nettype wire

//--- test/testbench.sv
// register level tests of the reload and baud timer
`timescale 1ns/1ps
`default_nettype none
`include "tbg_consts.svh"
module testbench;
  localparam logic [11:0] a_ctl = `TBG_OFF_CONTROL;
  localparam logic [11:0] a_mode = `TBG_OFF_MODE;
  localparam logic [11:0] a_rlo = `TBG_OFF_RELOAD_LO;
  localparam logic [11:0] a_clo = `TBG_OFF_COUNT_LO;
  localparam logic [11:0] a_chi = `TBG_OFF_COUNT_HI;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [`TBG_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic trig, cnt, t1_ovf, irq, tx_clk, rx_clk, oe;
  logic [7:0] enc [8] = '{8'h00, 8'h08, 8'h34, 8'h36, 8'h24, 8'h26, 8'h14, 8'h16};
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0, n0, n1;
  tbg_timer dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_direction_input(trig), .external_count_input(cnt), .timer1_overflow(t1_ovf),
    .timer_irq_req(irq), .tx_baud_clk(tx_clk), .rx_baud_clk(rx_clk), .timer_output_enable(oe));
  tbg_far_side far (.sys_clk(sys_clk), .rst_b(rst_b), .tx_baud_clk(tx_clk), .rx_baud_clk(rx_clk),
    .trigger_direction_input(trig), .external_count_input(cnt), .timer1_overflow(t1_ovf));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task in_range(input string what, input int v, input int lo, input int hi);
    check(what, (v >= lo && v <= hi), 32'h1);
  endtask : in_range
  // one apb transfer, entered just after a rising edge
  task apb(input logic w, input logic [`TBG_ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    // upper bytes carry copies of the data; the registers must ignore them
    pwdata <= {d, d, d, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) check("pready", pready, 32'h1);
    @(posedge sys_clk);
  endtask : apb
  task wr16(input logic [11:0] a, input logic [15:0] v);
    apb(1'b1, a, v[7:0]);
    apb(1'b1, a + 12'h004, v[15:8]);
  endtask : wr16
  task chk16(input string what, input logic [15:0] e);
    logic [7:0] lo;
    apb(1'b0, a_clo, 8'h00);
    lo = rd[7:0];
    apb(1'b0, a_chi, 8'h00);
    check(what, {rd[7:0], lo}, e);
  endtask : chk16
  task wait_flag(input int b, input int limit);
    int k;
    k = 0;
    do begin
      apb(1'b0, a_ctl, 8'h00);
      k++;
    end while (rd[b] !== 1'b1 && k < limit);
  endtask : wait_flag
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, a_ctl, 8'h00);
    check("control reset", rd, 32'h0);
    check("mapped no error", err, 32'h0);
    apb(1'b0, a_mode, 8'h00);
    check("mode reset", rd, 32'h0);
    apb(1'b0, 12'h040, 8'h00);
    check("unmapped error", err, 32'h1);
    check("unmapped read", rd, 32'h0);
    apb(1'b1, a_mode, 8'h02);
    check("output enable", oe, 32'h1);
    apb(1'b0, a_mode, 8'h00);
    check("mode readback", rd, 32'h2);
    apb(1'b1, a_mode, 8'h00);
    foreach (enc[i]) begin
      apb(1'b1, a_ctl, enc[i]);
      apb(1'b0, a_ctl, 8'h00);
      check("control code", rd, {24'h0, enc[i]});
    end
    apb(1'b1, a_ctl, 8'h00);
    wr16(a_rlo, 16'hFFF0);
    wr16(a_clo, 16'hFFF0);
    apb(1'b1, a_ctl, 8'h04);
    t0 = cyc;
    wait_flag(7, 150);
    n0 = cyc - t0;
    check("overflow flag", rd[7], 32'h1);
    in_range("machine tick span", n0, 180, 215);
    check("irq on overflow", irq, 32'h1);
    apb(1'b1, a_ctl, 8'h00);
    apb(1'b0, a_chi, 8'h00);
    check("reloaded high byte", rd[7:0], 32'hFF);
    check("irq cleared", irq, 32'h0);
    apb(1'b1, a_ctl, 8'h08);
    wr16(a_clo, 16'h1234);
    far.set_trig(1'b0);
    apb(1'b0, a_ctl, 8'h00);
    check("edge flag", rd[7:0], 32'h48);
    check("irq on edge", irq, 32'h1);
    chk16("trigger reload", 16'hFFF0);
    far.set_trig(1'b1);
    apb(1'b1, a_ctl, 8'h00);
    wr16(a_clo, 16'hFFFE);
    apb(1'b1, a_ctl, 8'h02);
    apb(1'b1, a_ctl, 8'h06);
    far.pulse_cnt();
    apb(1'b0, a_ctl, 8'h00);
    check("one event", rd[7], 32'h0);
    far.pulse_cnt();
    apb(1'b0, a_ctl, 8'h00);
    check("event overflow", rd[7], 32'h1);
    apb(1'b1, a_ctl, 8'h00);
    apb(1'b1, a_mode, 8'h01);
    wr16(a_rlo, 16'h0010);
    wr16(a_clo, 16'h0012);
    far.set_trig(1'b0);
    apb(1'b1, a_ctl, 8'h04);
    wait_flag(7, 100);
    apb(1'b1, a_ctl, 8'h40);
    check("underflow flags", rd[7:6], 32'h3);
    chk16("underflow load", 16'hFFFF);
    check("no irq from toggle", irq, 32'h0);
    far.set_trig(1'b1);
    apb(1'b1, a_ctl, 8'h44);
    wait_flag(7, 100);
    apb(1'b1, a_ctl, 8'h00);
    check("up overflow flags", rd[7:6], 32'h2);
    apb(1'b0, a_chi, 8'h00);
    check("up reload high", rd[7:0], 32'h00);
    apb(1'b1, a_mode, 8'h00);
    wr16(a_rlo, 16'hFFFE);
    wr16(a_clo, 16'hFFFE);
    n0 = far.tx_n;
    n1 = far.rx_n;
    apb(1'b1, a_ctl, 8'h35);
    repeat (640) @(posedge sys_clk);
    in_range("tx baud pulses", far.tx_n - n0, 9, 11);
    in_range("rx baud pulses", far.rx_n - n1, 9, 11);
    apb(1'b0, a_ctl, 8'h00);
    check("no baud overflow flag", rd[7], 32'h0);
    check("no baud irq", irq, 32'h0);
    apb(1'b1, a_ctl, 8'h14);
    n0 = far.tx_n;
    n1 = far.rx_n;
    repeat (640) @(posedge sys_clk);
    in_range("tx own timer", far.tx_n - n0, 9, 11);
    in_range("rx other timer", far.rx_n - n1, 4, 6);
    apb(1'b1, a_ctl, 8'h3C);
    far.set_trig(1'b0);
    apb(1'b0, a_ctl, 8'h00);
    check("baud edge flag", rd[7:6], 32'h1);
    check("baud edge irq", irq, 32'h1);
    far.set_trig(1'b1);
    apb(1'b1, a_ctl, 8'h00);
    wr16(a_rlo, 16'hFFFF);
    wr16(a_clo, 16'hFFFF);
    apb(1'b1, a_ctl, 8'h36);
    n0 = far.tx_n;
    repeat (16) far.pulse_cnt();
    check("external baud pulses", far.tx_n - n0, 32'h1);
    apb(1'b1, a_mode, 8'h01);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, a_mode, 8'h00);
    check("mode after reset", rd, 32'h0);
    apb(1'b0, a_ctl, 8'h00);
    check("control after reset", rd, 32'h0);
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
